// ---- rtl/ast_regs.svh ----
// Register offsets, field positions and reset values of the serial transmitter.
// Assumes a byte-addressed register port with 32-bit words.
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

`define AST_ADDR_W 8
`define AST_OFS_CTRL 8'h00
`define AST_OFS_DATA 8'h04
`define AST_OFS_BAUD 8'h08
`define AST_OFS_STAT 8'h0C

`define AST_CTRL_TRANSMIT_ENABLE_BIT 0
`define AST_CTRL_CLKMODE 1
`define AST_CTRL_SERIAL_PORT_ENABLE 2
`define AST_CTRL_NINE 3
`define AST_CTRL_NINTHD 4
`define AST_CTRL_POL 5
`define AST_CTRL_WIDE 6
`define AST_CTRL_HSPD 7
`define AST_CTRL_IE 8
`define AST_CTRL_W 9

`define AST_STAT_SHIFTER_EMPTY_STATUS 0
`define AST_STAT_TXIF 1

`define AST_CTRL_RST 9'h000
`define AST_BAUD_RST 16'h0000

`define AST_SHIFT_NARROW_LO 6
`define AST_SHIFT_NARROW_HI 4
`define AST_SHIFT_WIDE_LO 4
`define AST_SHIFT_WIDE_HI 2

`endif

// ---- rtl/ast_pkg.sv ----
// Types shared by the serial transmitter and its bench.
// Assumes ast_regs.svh for widths.
`include "ast_regs.svh"

package ast_pkg;

  typedef struct packed {
    logic [`AST_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ast_bus_req_t;

  typedef struct packed {
    logic tx_out;
    logic tx_oe_n;
  } ast_pin_t;

  typedef enum logic [3:0] {
    AST_IDLE = 4'h1,
    AST_START = 4'h2,
    AST_DATA = 4'h4,
    AST_STOP = 4'h8
  } ast_state_t;

endpackage

// ---- rtl/ast_tx.sv ----
// Asynchronous NRZ serial transmitter with holding buffer and baud generator.
// Assumes a single 50 MHz clock and a synchronous one-cycle register port.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "ast_regs.svh"

module ast_tx
  import ast_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire ast_bus_req_t bus_req,
  output logic [31:0] rdata,
  output ast_pin_t pin,
  output logic tx_irq,
  output logic shifter_empty
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (DIV_W != 16) begin : g_chk_div
    $error("ast_tx: divider must be 16 bits wide");
  end
  if (DATA_W != 8) begin : g_chk_data
    $error("ast_tx: character low part must be 8 bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [`AST_CTRL_W-1:0] ctrl_r;
  logic [DIV_W-1:0] baud_div_r;
  logic [DATA_W-1:0] hold_data_r;
  logic hold_ninth_r;
  logic hold_full_r;
  logic flag_r;
  logic shifter_empty_status_r;
  logic [31:0] rdata_r;

  logic wr_ctrl;
  logic wr_data;
  logic wr_baud;
  logic tx_active;
  logic pol_eff;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == `AST_OFS_CTRL);
  assign wr_data = bus_req.wr && (bus_req.addr == `AST_OFS_DATA);
  assign wr_baud = bus_req.wr && (bus_req.addr == `AST_OFS_BAUD);

  // Transmitter runs only in asynchronous mode with both enables set
  assign tx_active = ctrl_r[`AST_CTRL_TRANSMIT_ENABLE_BIT] && !ctrl_r[`AST_CTRL_CLKMODE] &&
                     ctrl_r[`AST_CTRL_SERIAL_PORT_ENABLE];
  assign pol_eff = ctrl_r[`AST_CTRL_POL] && !ctrl_r[`AST_CTRL_CLKMODE];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `AST_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= bus_req.wdata[`AST_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_div_r <= `AST_BAUD_RST;
    end else if (wr_baud) begin
      baud_div_r <= bus_req.wdata[DIV_W-1:0];
    end
  end

  // Unmapped reads return zero; data register reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `AST_OFS_CTRL: rdata_r <= {{(32-`AST_CTRL_W){1'b0}}, ctrl_r};
        `AST_OFS_BAUD: rdata_r <= {{(32-DIV_W){1'b0}}, baud_div_r};
        `AST_OFS_STAT: begin
          rdata_r <= 32'h0000_0000;
          rdata_r[`AST_STAT_SHIFTER_EMPTY_STATUS] <= shifter_empty_status_r;
          rdata_r[`AST_STAT_TXIF] <= flag_r;
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator

  localparam int PER_W = DIV_W + `AST_SHIFT_NARROW_LO + 1;

  logic [PER_W-1:0] baud_cnt_r;
  logic [PER_W-1:0] baud_per;
  logic [PER_W-1:0] div_ext;
  logic baud_tick;
  logic load_sh;

  // Narrow divider uses only the low byte
  always_comb begin
    div_ext = '0;
    if (ctrl_r[`AST_CTRL_WIDE]) begin
      div_ext[DIV_W-1:0] = baud_div_r;
    end else begin
      div_ext[7:0] = baud_div_r[7:0];
    end
    div_ext = div_ext + {{(PER_W-1){1'b0}}, 1'b1};
    case ({ctrl_r[`AST_CTRL_WIDE], ctrl_r[`AST_CTRL_HSPD]})
      2'b00: baud_per = div_ext << `AST_SHIFT_NARROW_LO;
      2'b01: baud_per = div_ext << `AST_SHIFT_NARROW_HI;
      2'b10: baud_per = div_ext << `AST_SHIFT_WIDE_LO;
      default: baud_per = div_ext << `AST_SHIFT_WIDE_HI;
    endcase
  end

  assign baud_tick = (baud_cnt_r == baud_per - {{(PER_W-1){1'b0}}, 1'b1});

  // Restart on every load so the start bit gets a full period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_cnt_r <= '0;
    end else if (load_sh || !tx_active || baud_tick) begin
      baud_cnt_r <= '0;
    end else begin
      baud_cnt_r <= baud_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer and shifter

  ast_state_t state_r;
  ast_state_t state_nxt;
  logic [DATA_W:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] last_bit;
  logic load_direct;
  logic load_hold;

  assign last_bit = ctrl_r[`AST_CTRL_NINE] ? 4'h8 : 4'h7;
  assign load_direct = wr_data && tx_active && (state_r == AST_IDLE) && !hold_full_r;
  assign load_hold = tx_active && hold_full_r &&
                     ((state_r == AST_IDLE) || ((state_r == AST_STOP) && baud_tick));
  assign load_sh = load_direct || load_hold;

  // A write while the buffer is already full is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_full_r <= 1'b0;
      hold_data_r <= '0;
      hold_ninth_r <= 1'b0;
    end else if (!tx_active) begin
      hold_full_r <= 1'b0;
    end else if (wr_data && !load_direct && !hold_full_r) begin
      hold_full_r <= 1'b1;
      hold_data_r <= bus_req.wdata[DATA_W-1:0];
      hold_ninth_r <= ctrl_r[`AST_CTRL_NINTHD];
    end else if (load_hold) begin
      hold_full_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AST_IDLE: if (load_sh) state_nxt = AST_START;
      AST_START: if (baud_tick) state_nxt = AST_DATA;
      AST_DATA: if (baud_tick && bit_cnt_r == last_bit) state_nxt = AST_STOP;
      AST_STOP: if (baud_tick) state_nxt = load_hold ? AST_START : AST_IDLE;
      default: state_nxt = AST_IDLE;
    endcase
    if (!tx_active) begin
      state_nxt = AST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= AST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Parity is never computed here; the ninth bit is taken as given
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      bit_cnt_r <= 4'h0;
    end else if (load_direct) begin
      shift_r <= {ctrl_r[`AST_CTRL_NINTHD], bus_req.wdata[DATA_W-1:0]};
      bit_cnt_r <= 4'h0;
    end else if (load_hold) begin
      shift_r <= {hold_ninth_r, hold_data_r};
      bit_cnt_r <= 4'h0;
    end else if (state_r == AST_DATA && baud_tick) begin
      shift_r <= {1'b0, shift_r[DATA_W:1]};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shifter_empty_status_r <= 1'b1;
    end else begin
      shifter_empty_status_r <= (state_nxt == AST_IDLE);
    end
  end

  // Flag lags the buffer by one cycle, so it is valid two cycles after a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= ctrl_r[`AST_CTRL_TRANSMIT_ENABLE_BIT] && !hold_full_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and interrupt outputs

  logic line_lvl;
  logic tx_out_r;
  logic tx_oe_n_r;
  logic irq_r;

  always_comb begin
    case (state_r)
      AST_START: line_lvl = 1'b0;
      AST_DATA: line_lvl = shift_r[0];
      default: line_lvl = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_out_r <= 1'b1;
      tx_oe_n_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      tx_out_r <= line_lvl ^ pol_eff;
      tx_oe_n_r <= !ctrl_r[`AST_CTRL_SERIAL_PORT_ENABLE];
      irq_r <= flag_r && ctrl_r[`AST_CTRL_IE];
    end
  end

  assign rdata = rdata_r;
  assign pin.tx_out = tx_out_r;
  assign pin.tx_oe_n = tx_oe_n_r;
  assign tx_irq = irq_r;
  assign shifter_empty = shifter_empty_status_r;

endmodule // ast_tx

// ---- tb/ast_tx_chk.sv ----
// Port checker for ast_tx, bound to every instance.
// Assumes the ast_regs.svh register map and BAUD/CTRL written only over bus_req.
`timescale 1ns/100ps
`include "ast_regs.svh"

module ast_tx_chk
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ast_bus_req_t bus_req,
  input wire ast_pin_t pin,
  input wire logic tx_irq,
  input wire logic shifter_empty
);
  logic [8:0] ctrl_q;
  logic [15:0] baud_q;
  logic tx_q, act, mark, dwr, cwr;
  int run_r, quiet_r, per;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign cwr = bus_req.wr && bus_req.addr == `AST_OFS_CTRL;
  assign dwr = bus_req.wr && bus_req.addr == `AST_OFS_DATA;
  assign act = ctrl_q[0] && !ctrl_q[1] && ctrl_q[2];
  assign mark = !(ctrl_q[5] && !ctrl_q[1]);
  // Bit length shadowed from writes, so divider faults show up
  assign per = ((ctrl_q[6] ? int'(baud_q) : int'(baud_q[7:0])) + 1)
    * (ctrl_q[6] && ctrl_q[7] ? 4 : (ctrl_q[6] || ctrl_q[7] ? 16 : 64));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `AST_CTRL_RST;
      baud_q <= `AST_BAUD_RST;
      tx_q <= 1'h1;
      run_r <= 1;
      quiet_r <= 9;
    end else begin
      if (cwr) ctrl_q <= bus_req.wdata[8:0];
      if (bus_req.wr && bus_req.addr == `AST_OFS_BAUD) baud_q <= bus_req.wdata[15:0];
      tx_q <= pin.tx_out;
      run_r <= (pin.tx_out != tx_q) ? 1 : run_r + 1;
      quiet_r <= cwr ? 0 : (quiet_r < 9 ? quiet_r + 1 : 9);
    end
  end
  ////////////////////////////////////////
  // Guards skip the few cycles where a CTRL change is still in flight
  property p_idle;
    shifter_empty && quiet_r > 3 && !$past(dwr) && !$past(dwr, 2) |-> pin.tx_out == mark;
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_oe;
    pin.tx_oe_n == !$past(ctrl_q[2]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_load;
    dwr && act && shifter_empty |-> ##[1:3] !shifter_empty;
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_busy;
    $fell(shifter_empty) |-> !shifter_empty [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy drop");
  property p_run;
    pin.tx_out != tx_q && pin.tx_out == mark && act && quiet_r > 3 |-> run_r % per == 0;
  endproperty
  a_run: assert property (p_run) else $error("bit length");
  property p_ten;
    cwr && bus_req.wdata[0] && bus_req.wdata[8] && shifter_empty |-> ##[2:4] tx_irq;
  endproperty
  a_ten: assert property (p_ten) else $error("flag on enable");
  property p_mask;
    !ctrl_q[8] && quiet_r > 1 |-> !tx_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  property p_queue;
    dwr && act && ctrl_q[8] && !shifter_empty && quiet_r > 3 |-> ##[1:4] !tx_irq;
  endproperty
  a_queue: assert property (p_queue) else $error("flag on queue");
  property p_off;
    !act [*4] |-> shifter_empty;
  endproperty
  a_off: assert property (p_off) else $error("sends while off");
  c_b2b: cover property (dwr && act && !shifter_empty);
  c_irq: cover property ($rose(tx_irq));
  c_abort: cover property ($rose(shifter_empty) && !act);
endmodule // ast_tx_chk

bind ast_tx ast_tx_chk u_chk (.clk(clk), .rst(rst), .bus_req(bus_req), .pin(pin),
  .tx_irq(tx_irq), .shifter_empty(shifter_empty));

// ---- tb/ast_rx_model.sv ----
// Far-end receiver model, sampling the line at mid-bit.
// Assumes a mark-idle line and P clocks per bit.
`timescale 1ns/100ps

module ast_rx_model #(
  parameter int P = 4
) (
  input wire logic clk,
  input wire logic line,
  input wire logic nine,
  output logic [8:0] char_q,
  output logic ferr,
  output int cnt
);
  initial begin
    char_q = '0;
    ferr = 1'h0;
    cnt = 0;
    forever begin
      @(negedge line);
      repeat (P / 2) @(posedge clk);
      // A start bit gone by mid-bit is a glitch, not a frame
      if (line) continue;
      char_q = '0;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (P) @(posedge clk);
        char_q[i] = line;
      end
      repeat (P) @(posedge clk);
      ferr = ferr | !line;
      cnt++;
    end
  end
endmodule // ast_rx_model

// ---- tb/tb_top.sv ----
// Bench for ast_tx with a far-end receiver model.
// Assumes 4-clock bits: BAUD 0 with wide and high-speed divider.
`timescale 1ns/100ps
`include "ast_regs.svh"

module tb_top
  import ast_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  ast_bus_req_t req = '0;
  logic [31:0] rdata;
  ast_pin_t pin;
  logic tx_irq, shifter_empty, rx_err;
  logic inv = 1'h0;
  logic nine = 1'h0;
  logic [8:0] rx_char;
  int rx_cnt, n;
  int failures = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  ast_tx DUT (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata), .pin(pin),
    .tx_irq(tx_irq), .shifter_empty(shifter_empty));
  ast_rx_model #(.P(4)) u_rx (.clk(clk), .line(pin.tx_out ^ inv), .nine(nine),
    .char_q(rx_char), .ferr(rx_err), .cnt(rx_cnt));
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic w = 1'h1);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req.wr <= 1'h0;
    req.rd <= 1'h0;
  endtask
  task automatic rchk(string s, logic [7:0] a, logic [31:0] e);
    wr(a, 32'h0, 1'h0);
    @(negedge clk);
    chk(s, rdata, e);
  endtask
  task automatic rx(int k, logic [8:0] e);
    repeat (3000) if (rx_cnt < k) @(posedge clk);
    chk("rx count", 32'(rx_cnt >= k), 32'h1);
    chk("rx", 32'(rx_char), 32'(e));
  endtask
  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rchk("stat", `AST_OFS_STAT, 32'h1);
    rchk("hole", 8'h10, 32'h0);
    chk("pin", 32'(pin), 32'h3);
    wr(`AST_OFS_BAUD, 32'h0);
    wr(`AST_OFS_CTRL, 32'h1C5);
    rchk("flag", `AST_OFS_STAT, 32'h3);
    chk("oe", 32'(pin), 32'h2);
    chk("irq", 32'(tx_irq), 32'h1);
    wr(`AST_OFS_DATA, 32'hA5);
    wr(`AST_OFS_DATA, 32'h3C);
    rchk("queued", `AST_OFS_STAT, 32'h0);
    rx(1, 9'h0A5);
    rx(2, 9'h03C);
    chk("frame", 32'(rx_err), 32'h0);
    nine <= 1'h1;
    wr(`AST_OFS_CTRL, 32'h1DD);
    wr(`AST_OFS_DATA, 32'h5A);
    rx(3, 9'h15A);
    nine <= 1'h0;
    wr(`AST_OFS_CTRL, 32'h1E5);
    inv <= 1'h1;
    // Polarity flip may look like a start bit to the model
    repeat (60) @(posedge clk);
    chk("inv", 32'(pin.tx_out), 32'h0);
    n = rx_cnt;
    wr(`AST_OFS_DATA, 32'h81);
    rx(n + 1, 9'h081);
    wr(`AST_OFS_CTRL, 32'h1E7);
    wr(`AST_OFS_DATA, 32'h55);
    repeat (4) @(posedge clk);
    chk("sync", 32'({pin, shifter_empty}), 32'h5);
    inv <= 1'h0;
    wr(`AST_OFS_CTRL, 32'h1C5);
    wr(`AST_OFS_DATA, 32'h0);
    repeat (20) @(posedge clk);
    wr(`AST_OFS_CTRL, 32'h0C4);
    repeat (4) @(posedge clk);
    chk("abort", 32'({pin, tx_irq}), 32'h4);
    wr(`AST_OFS_CTRL, 32'h0C5);
    rchk("no ie", `AST_OFS_STAT, 32'h3);
    chk("irq", 32'(tx_irq), 32'h0);
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end
endmodule // tb_top
